// ===== pvsb_pkg.sv
// constants shared by the valve servo and its boost channels
// assumes a 125 MHz core clock and percent values scaled by 100
`default_nettype none

package pvsb_pkg;

	// ********************************************************
	// scaling and timing
	// ********************************************************
	localparam int CLK_PERIOD_NS    = 8;
	localparam int SAMPLE_PERIOD_US = 1000;            // control law rate
	localparam int SAMPLE_CYCLES    =
		(SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
	localparam int PCT_FULL         = 10000;           // 100.00 percent
	localparam int PCT_QUAD_CLAMP   = 1000;            // 10.00 percent
	localparam int GAIN_UNIT        = 10;              // gains in tenths
	localparam int GAIN_NORM        = 100;             // output per error
	localparam int TI_UNIT_US       = 100000;          // integral time 0.1 s
	localparam int TI_SAMPLES       = TI_UNIT_US / SAMPLE_PERIOD_US;
	localparam int MS_SAMPLES_NUM   = 1000;            // times in ms
	localparam int DLAG_DEN_SCALE   =
		(MS_SAMPLES_NUM / SAMPLE_PERIOD_US) * GAIN_UNIT;
	localparam int XF_FRAC          = 16;              // lag state fraction

	// ********************************************************
	// parameter ranges, in port units
	// ********************************************************
	localparam logic [15:0] LG_MIN   = 16'h0001;     // 0.1
	localparam logic [15:0] LG_MAX   = 16'h32c8;     // 1300.0
	localparam logic [15:0] LG_RST   = 16'h04b0;     // 120.0
	localparam logic [15:0] PG_MIN   = 16'h0005;     // 0.5 rad/mA
	localparam logic [15:0] PG_MAX   = 16'h01f4;     // 50.0 rad/mA
	localparam logic [15:0] TI_MIN   = 16'h0014;     // 2.0 s
	localparam logic [15:0] TI_MAX   = 16'h01f4;     // 50.0 s
	localparam logic [15:0] TD_MIN   = 16'h0032;     // 50 ms
	localparam logic [15:0] TD_MAX   = 16'h03e8;     // 1000 ms
	localparam logic [15:0] DG_MIN   = 16'h0014;     // 2.0
	localparam logic [15:0] DG_MAX   = 16'h00c8;     // 20.0
	localparam logic [15:0] BAND_MAX = 16'h1388;     // 50.00 percent
	localparam logic [15:0] OUT_MAX  = 16'h2710;     // 100.00 percent
	localparam logic [15:0] OUT_RST  = 16'h157c;     // 55.00 percent
	localparam logic [15:0] THR_MIN  = 16'h000a;     // 0.10 percent
	localparam logic [15:0] THR_MAX  = 16'h03e8;     // 10.00 percent
	localparam logic [15:0] AMT_MAX  = 16'h1388;     // 50.00 percent
	localparam logic [15:0] HOLD_MAX = 16'h2710;     // 10000 ms

	// signed exhaust deltas
	localparam logic signed [15:0] XTHR_LIM = 16'sh03e8;
	localparam logic signed [15:0] XAMT_LIM = 16'sh1388;

	typedef logic signed [63:0] pvsb_wide_t;

endpackage

`default_nettype wire

// ===== pvsb_boost_if.sv
// carrier between the servo core and one boost channel
// assumes the core drives events and settings, the channel answers
`default_nettype none

interface pvsb_boost_if;
	logic                tick;
	logic                step_pulse;
	logic signed [16:0]  step;
	logic [16:0]         abs_err;
	logic                double_acting;
	logic [15:0]         on_thr;
	logic [15:0]         off_thr;
	logic [15:0]         amount;
	logic signed [15:0]  x_on;
	logic signed [15:0]  x_off;
	logic signed [15:0]  x_amt;
	logic                block;
	logic                exceeds;
	logic                active;
	logic                dir_down;
	logic [15:0]         boost;

	modport ctrl (
		output tick, step_pulse, step, abs_err, double_acting,
		output on_thr, off_thr, amount, x_on, x_off, x_amt, block,
		input  exceeds, active, dir_down, boost
	);
	modport chan (
		input  tick, step_pulse, step, abs_err, double_acting,
		input  on_thr, off_thr, amount, x_on, x_off, x_amt, block,
		output exceeds, active, dir_down, boost
	);
endinterface

`default_nettype wire

// ===== pvsb_boost_chan.sv
// one set-point step boost level with its engage and release logic
// assumes settings already range-limited by the servo core
`default_nettype none

module pvsb_boost_chan (
	input  wire logic    core_clk,
	input  wire logic    rstn,
	pvsb_boost_if.chan   bif
);

	logic               step_down;
	logic signed [17:0] on_eff;
	logic signed [17:0] off_eff;
	logic signed [17:0] amt_eff;
	logic signed [17:0] step_mag;

	// ********************************************************
	// effective settings, exhaust deltas on downward steps
	// ********************************************************
	always_comb begin
		step_down = bif.step < 0;
		step_mag  = step_down ? -18'(bif.step) : 18'(bif.step);
		on_eff    = 18'(signed'({2'b00, bif.on_thr}));
		if (step_down && bif.double_acting) begin
			on_eff = on_eff + 18'(bif.x_on);                  // [R14]
		end
		off_eff = 18'(signed'({2'b00, bif.off_thr}));
		amt_eff = 18'(signed'({2'b00, bif.amount}));
		if (bif.dir_down && bif.double_acting) begin
			off_eff = off_eff + 18'(bif.x_off);               // [R14]
			amt_eff = amt_eff + 18'(bif.x_amt);               // [R14]
		end
		if (amt_eff < 0) begin
			amt_eff = '0;
		end
	end

	// step larger than engage level; single acting only boosts supply
	assign bif.exceeds = (bif.on_thr != 16'h0000) &&
		(step_mag > on_eff) &&
		(!step_down || bif.double_acting);                        // [R11] [R13]

	// engage on a step, release once the deviation is small
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bif.active   <= 1'b0;
			bif.dir_down <= 1'b0;
		end else if (bif.step_pulse) begin
			bif.active   <= bif.exceeds && !bif.block;            // [R12]
			bif.dir_down <= step_down;
		end else if (bif.tick && bif.active &&
				(18'(signed'({1'b0, bif.abs_err})) <= off_eff)) begin
			bif.active   <= 1'b0;                                 // [R11]
		end
	end

	// boost amount presented while active
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bif.boost <= 16'h0000;
		end else begin
			bif.boost <= bif.active ? amt_eff[15:0] : 16'h0000;
		end
	end

endmodule

`default_nettype wire

// ===== pvsb_servo.sv
// valve position servo: PI-D law with boost, drives the I/P converter
// assumes set point and position come from logic on core_clk, and
// tuning inputs only change while the loop is out of service
//
// How it works
// R01: loop gain limited to 0.1..1300
// R02: proportional gain is loop over plant gain
// R03: integral time 0 or 2..50 s, 0 off
// R04: integral grows by error over integral time
// R05: derivative time 0 or 50..1000 ms, 0 off
// R06: derivative acts on position, scales with time
// R07: derivative gain 2..20 scales damping
// R08: integral frozen inside the stop band
// R09: startup level drives output and integral base
// R10: two boost levels with range-limited settings
// R11: boost added on big step, removed near target
// R12: larger step uses second level alone
// R13: double acting also boosts the exhaust side
// R14: exhaust deltas added only when double acting
// R15: deviation change holds integral for hold time
// R16: hold only outside band, off if band zero
// R17: quadratic term added when divisor nonzero
// R18: quadratic term clamped at ten percent error
// R19: plant gain estimate limited to 0.5..50
// R20: host tunes only while loop out of service
// R21: fixed-point law per sample, output clamped
// R22: derivative lag constant is time over gain
`default_nettype none

module pvsb_servo #(
	parameter int SAMPLE_CYCLES = pvsb_pkg::SAMPLE_CYCLES
) (
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	input  wire logic [15:0]              set_point,
	input  wire logic [15:0]              valve_position,
	input  wire logic                     double_acting,
	input  wire logic [15:0]              loop_gain_setting,
	input  wire logic [15:0]              plant_gain_estimate,
	input  wire logic [15:0]              integral_time,
	input  wire logic [15:0]              derivative_time,
	input  wire logic [15:0]              derivative_term_gain,
	input  wire logic [15:0]              integral_stop_band,
	input  wire logic [15:0]              startup_output_level,
	input  wire logic [15:0]              integral_hold_time,
	input  wire logic [15:0]              quadratic_prop_divisor,
	input  wire logic [1:0][15:0]         kick_engage,
	input  wire logic [1:0][15:0]         kick_release,
	input  wire logic [1:0][15:0]         kick_amount,
	input  wire logic [1:0][15:0]         vent_kick_engage_delta,
	input  wire logic [1:0][15:0]         vent_kick_release_delta,
	input  wire logic [1:0][15:0]         vent_kick_amount_delta,
	output logic [15:0]                   pneumatic_output_a,
	output logic [15:0]                   pneumatic_output_b,
	output logic [15:0]                   drive_output_reading,
	output logic [1:0]                    boost_active,
	output logic                          integral_held
);

	// ********************************************************
	// declarations
	// ********************************************************
	localparam int CW = $clog2(SAMPLE_CYCLES + 1);
	localparam pvsb_pkg::pvsb_wide_t QUAD_LIM = pvsb_pkg::PCT_QUAD_CLAMP;
	localparam pvsb_pkg::pvsb_wide_t FULL_SCALE = pvsb_pkg::PCT_FULL;

	logic [CW-1:0]        smp_cnt;
	logic                 tick;
	logic                 primed;
	logic [15:0]          sp_prev;
	logic [15:0]          hold_cnt;
	pvsb_pkg::pvsb_wide_t integ;
	pvsb_pkg::pvsb_wide_t xf;

	logic signed [15:0]   lg, pg, ti, td, dg, qdiv;
	logic [15:0]          band, base, hold;
	logic [1:0][15:0]     on_l, off_l, amt_l;
	logic [1:0][15:0]     xon_l, xoff_l, xamt_l;

	pvsb_pkg::pvsb_wide_t err, aerr, qe, quad, p_term, i_term, d_term;
	pvsb_pkg::pvsb_wide_t mv, up, dn, out_a, next_integ, next_xf;
	logic                 step_pulse;
	logic                 in_band;
	logic                 freeze;
	logic                 hold_start;
	logic [1:0]           k_act, k_dn;
	logic [1:0][15:0]     k_amt;

	pvsb_boost_if bif[2] ();

	// ********************************************************
	// range limits for tuning inputs
	// ********************************************************
	function automatic logic [15:0] fit(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		logic [15:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction

	function automatic logic [15:0] fit_z(input logic [15:0] v,
			input logic [15:0] lo, input logic [15:0] hi);
		return (v == 16'h0000) ? 16'h0000 : fit(v, lo, hi);
	endfunction

	function automatic logic [15:0] fit_s(input logic [15:0] v,
			input logic signed [15:0] lim);
		logic signed [15:0] s;
		s = signed'(v);
		if (s > lim) begin
			s = lim;
		end else if (s < -lim) begin
			s = -lim;
		end
		return unsigned'(s);
	endfunction

	// tuning taken live; host keeps them still while in service [R20]
	always_comb begin
		lg   = fit(loop_gain_setting, pvsb_pkg::LG_MIN,
			pvsb_pkg::LG_MAX);                                    // [R01]
		pg   = fit(plant_gain_estimate, pvsb_pkg::PG_MIN,
			pvsb_pkg::PG_MAX);                                    // [R19]
		ti   = fit_z(integral_time, pvsb_pkg::TI_MIN,
			pvsb_pkg::TI_MAX);                                    // [R03]
		td   = fit_z(derivative_time, pvsb_pkg::TD_MIN,
			pvsb_pkg::TD_MAX);                                    // [R05]
		dg   = fit(derivative_term_gain, pvsb_pkg::DG_MIN,
			pvsb_pkg::DG_MAX);                                    // [R07]
		band = fit(integral_stop_band, 16'h0000, pvsb_pkg::BAND_MAX);
		base = fit(startup_output_level, 16'h0000, pvsb_pkg::OUT_MAX);
		hold = fit(integral_hold_time, 16'h0000, pvsb_pkg::HOLD_MAX);
		qdiv = fit(quadratic_prop_divisor, 16'h0000, pvsb_pkg::OUT_MAX);
		for (int k = 0; k < 2; k++) begin
			on_l[k]   = fit_z(kick_engage[k], pvsb_pkg::THR_MIN,
				pvsb_pkg::THR_MAX);                               // [R10]
			off_l[k]  = fit(kick_release[k], pvsb_pkg::THR_MIN,
				pvsb_pkg::THR_MAX);                               // [R10]
			amt_l[k]  = fit(kick_amount[k], 16'h0000,
				pvsb_pkg::AMT_MAX);                               // [R10]
			xon_l[k]  = fit_s(vent_kick_engage_delta[k],
				pvsb_pkg::XTHR_LIM);                              // [R14]
			xoff_l[k] = fit_s(vent_kick_release_delta[k],
				pvsb_pkg::XTHR_LIM);                              // [R14]
			xamt_l[k] = fit_s(vent_kick_amount_delta[k],
				pvsb_pkg::XAMT_LIM);                              // [R14]
		end
	end

	// ********************************************************
	// sample timing
	// ********************************************************

	// free-running divider, one tick per sample period
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			smp_cnt <= '0;
			tick    <= 1'b0;
		end else if (smp_cnt == CW'(SAMPLE_CYCLES - 1)) begin
			smp_cnt <= '0;
			tick    <= 1'b1;                                      // [R21]
		end else begin
			smp_cnt <= smp_cnt + CW'(1);
			tick    <= 1'b0;
		end
	end

	// first cycle after reset takes the present set point as reference
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			primed  <= 1'b0;
			sp_prev <= 16'h0000;
		end else if (!primed || tick) begin
			primed  <= 1'b1;
			sp_prev <= set_point;
		end
	end

	// ********************************************************
	// control law
	// ********************************************************
	always_comb begin
		err  = pvsb_pkg::pvsb_wide_t'(signed'({1'b0, set_point})) -
			pvsb_pkg::pvsb_wide_t'(signed'({1'b0, valve_position}));
		aerr = (err < 0) ? -err : err;
		step_pulse = tick && (set_point != sp_prev);

		// quadratic boost of the proportional term
		qe = err;
		if (qe > QUAD_LIM) begin
			qe = QUAD_LIM; // [R18]
		end else if (qe < -QUAD_LIM) begin
			qe = -QUAD_LIM; // [R18]
		end
		quad = '0;
		if (qdiv != 16'h0000) begin
			quad = (qe * ((qe < 0) ? -qe : qe)) / qdiv;            // [R17]
		end
		p_term = ((err + quad) * lg) / (pg * pvsb_pkg::GAIN_NORM); // [R02]

		// integral about the startup base
		i_term = '0;
		if (ti != 16'h0000) begin
			i_term = integ / (pvsb_pkg::pvsb_wide_t'(pg) *
				pvsb_pkg::GAIN_NORM * ti * pvsb_pkg::TI_SAMPLES); // [R04]
		end

		// derivative on position through a first-order lag
		next_xf = pvsb_pkg::pvsb_wide_t'(valve_position) <<<
			pvsb_pkg::XF_FRAC;
		d_term  = '0;
		if (td != 16'h0000) begin
			next_xf = xf + ((next_xf - xf) * dg) /
				(td * pvsb_pkg::DLAG_DEN_SCALE);                  // [R22]
			d_term  = -(((pvsb_pkg::pvsb_wide_t'(valve_position) -
				(xf >>> pvsb_pkg::XF_FRAC)) * lg * dg) /
				(pg * pvsb_pkg::GAIN_NORM * pvsb_pkg::GAIN_UNIT)); // [R06] [R07]
		end

		mv = pvsb_pkg::pvsb_wide_t'(base) + i_term + p_term + d_term; // [R09]
		if (mv < 0) begin
			mv = '0;                                              // [R21]
		end else if (mv > FULL_SCALE) begin
			mv = FULL_SCALE; // [R21]
		end

		// integral gating: stop band and hold timer
		in_band    = aerr <= pvsb_pkg::pvsb_wide_t'(band);        // [R08]
		hold_start = step_pulse && (band != 16'h0000) && !in_band &&
			(hold != 16'h0000);                                   // [R16]
		freeze     = in_band || (hold_cnt != 16'h0000) || hold_start;
		next_integ = integ;
		if (ti == 16'h0000) begin
			next_integ = '0;                                      // [R03]
		end else if (!freeze) begin
			next_integ = integ + err * lg;                        // [R04]
		end

		// boost sums per side
		up = '0;
		dn = '0;
		for (int k = 0; k < 2; k++) begin
			if (k_act[k] && !k_dn[k]) begin
				up = up + pvsb_pkg::pvsb_wide_t'(k_amt[k]);
			end else if (k_act[k]) begin
				dn = dn + pvsb_pkg::pvsb_wide_t'(k_amt[k]);   // [R13]
			end
		end
		out_a = mv + up - dn;                                     // [R11]
		if (out_a < 0) begin
			out_a = '0;
		end else if (out_a > FULL_SCALE) begin
			out_a = FULL_SCALE; // [R21]
		end
	end

	// ********************************************************
	// state updates
	// ********************************************************

	// integrator and derivative lag advance once per sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			integ <= '0;
			xf    <= '0;
		end else if (!primed) begin
			integ <= '0;
			xf    <= pvsb_pkg::pvsb_wide_t'(valve_position) <<<
				pvsb_pkg::XF_FRAC;
		end else if (tick) begin
			integ <= next_integ;
			xf    <= next_xf;
		end
	end

	// integral hold counted in samples after a set-point change
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			hold_cnt <= 16'h0000;
		end else if (hold_start) begin
			hold_cnt <= hold;                                     // [R15]
		end else if (tick && hold_cnt != 16'h0000) begin
			hold_cnt <= hold_cnt - 16'h0001;                      // [R15]
		end
	end

	// ********************************************************
	// boost channels
	// ********************************************************
	for (genvar g = 0; g < 2; g++) begin : g_kick
		assign bif[g].tick          = tick;
		assign bif[g].step_pulse    = step_pulse && primed;
		assign bif[g].step          = 17'(signed'({1'b0, set_point})) -
			17'(signed'({1'b0, sp_prev}));
		assign bif[g].abs_err       = aerr[16:0];
		assign bif[g].double_acting = double_acting;
		assign bif[g].on_thr        = on_l[g];
		assign bif[g].off_thr       = off_l[g];
		assign bif[g].amount        = amt_l[g];
		assign bif[g].x_on          = signed'(xon_l[g]);
		assign bif[g].x_off         = signed'(xoff_l[g]);
		assign bif[g].x_amt         = signed'(xamt_l[g]);
		assign k_act[g]             = bif[g].active;
		assign k_dn[g]              = bif[g].dir_down;
		assign k_amt[g]             = bif[g].boost;

		pvsb_boost_chan u_chan (
			.core_clk (core_clk),
			.rstn     (rstn),
			.bif      (bif[g])
		);
	end

	// second level wins, first level stands aside
	assign bif[0].block = bif[1].exceeds;                         // [R12]
	assign bif[1].block = 1'b0;

	// ********************************************************
	// outputs
	// ********************************************************

	// converter drive and readings, startup level until first sample
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pneumatic_output_a   <= pvsb_pkg::OUT_RST;
			pneumatic_output_b   <= 16'h0000;
			drive_output_reading <= pvsb_pkg::OUT_RST;
		end else if (!primed) begin
			pneumatic_output_a   <= base;                         // [R09]
			pneumatic_output_b   <= double_acting ?
				pvsb_pkg::OUT_MAX - base : 16'h0000;
			drive_output_reading <= base;                         // [R09]
		end else if (tick) begin
			pneumatic_output_a   <= out_a[15:0];
			pneumatic_output_b   <= double_acting ?
				pvsb_pkg::OUT_MAX - out_a[15:0] : 16'h0000;       // [R13]
			drive_output_reading <= mv[15:0];
		end
	end

	// status flags
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			boost_active  <= 2'b00;
			integral_held <= 1'b0;
		end else begin
			boost_active  <= k_act;
			integral_held <= freeze || (ti == 16'h0000);
		end
	end

endmodule

`default_nettype wire

// ===== pvsb_servo_chk.sv
// port checker for the valve position servo
// assumes a bind into pvsb_servo, one clock domain
`default_nettype none

module pvsb_servo_chk #(
	parameter int SAMPLE_CYCLES = 50
) (
	input wire logic             core_clk,
	input wire logic             rstn,
	input wire logic             double_acting,
	input wire logic [15:0]      integral_time,
	input wire logic [15:0]      startup_output_level,
	input wire logic [1:0][15:0] kick_engage,
	input wire logic [15:0]      pneumatic_output_a,
	input wire logic [15:0]      pneumatic_output_b,
	input wire logic [15:0]      drive_output_reading,
	input wire logic [1:0]       boost_active,
	input wire logic             integral_held
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************
	// helper counters
	// ****************************************************
	int          gap;
	int          z_cnt;
	int          sa_cnt;
	int          nb_cnt;
	logic [15:0] prev_a;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// cycles since output a last moved, and settle counts
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			gap <= 1 << 20;
			prev_a <= 16'h157c;
			z_cnt <= 0;
			sa_cnt <= 0;
			nb_cnt <= 1;
		end else begin
			prev_a <= pneumatic_output_a;
			gap <= (pneumatic_output_a != prev_a) ? 1 : gap + 1;
			z_cnt <= (integral_time == 16'h0000) ? z_cnt + 1 : 0;
			sa_cnt <= double_acting ? 0 : sa_cnt + 1;
			nb_cnt <= (kick_engage != '0 || nb_cnt == 0) ? 0 : nb_cnt + 1;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	chk_reset_state: assert property (disable iff (1'b0)
		!rstn |=> pneumatic_output_a == 16'h157c && pneumatic_output_b == 16'h0
		&& boost_active == 2'b00 && !integral_held)
		else $error("outputs wrong during reset");
	chk_start_level: assert property (
		$rose(rstn) |=> pneumatic_output_a == startup_output_level)
		else $error("startup level not driven");
	chk_pair_sum: assert property (
		pneumatic_output_b == 16'h0 ||
		{1'b0, pneumatic_output_a} + {1'b0, pneumatic_output_b} == 17'h02710)
		else $error("output b not complement of a");
	chk_out_range: assert property (
		pneumatic_output_a <= 16'h2710 && drive_output_reading <= 16'h2710)
		else $error("drive outside full scale");
	chk_sample_gap: assert property (
		pneumatic_output_a != prev_a |-> gap >= SAMPLE_CYCLES - 1)
		else $error("drive moved between samples");
	chk_ti_off_held: assert property (
		z_cnt >= 2 * SAMPLE_CYCLES |-> integral_held)
		else $error("integral runs with zero time");
	chk_single_b: assert property (
		sa_cnt >= 2 * SAMPLE_CYCLES |-> pneumatic_output_b == 16'h0)
		else $error("output b driven when single acting");
	chk_no_boost: assert property (
		nb_cnt >= 2 * SAMPLE_CYCLES |-> boost_active == 2'b00
		&& pneumatic_output_a == drive_output_reading)
		else $error("boost with levels off");

	cover property (boost_active == 2'b01);
	cover property (boost_active == 2'b10);
	cover property (double_acting && pneumatic_output_b != 16'h0);
endmodule

bind pvsb_servo pvsb_servo_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
	.core_clk, .rstn, .double_acting, .integral_time,
	.startup_output_level, .kick_engage, .pneumatic_output_a,
	.pneumatic_output_b, .drive_output_reading, .boost_active,
	.integral_held
);

`default_nettype wire

// ===== pvsb_valve_model.sv
// valve and converter stand-in: gives the measured position
// assumes drive in percent x100; forced mode lets the bench pin it
`default_nettype none

module pvsb_valve_model (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [15:0] drive,
	input  wire logic        follow,
	input  wire logic [15:0] forced_pos,
	output logic [15:0]      position
);
	timeunit 1ns;
	timeprecision 1ps;
	// slew one count per cycle toward the drive when following
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn || !follow)
			position <= forced_pos;
		else if (position < drive)
			position <= position + 16'h0001;
		else if (position > drive)
			position <= position - 16'h0001;
	end
endmodule

`default_nettype wire

// ===== pvsb_servo_tb.sv
// self-checking bench for the valve position servo
// assumes package, servo, checker and valve model compiled before it
`default_nettype none

module pvsb_servo_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************
	// stimulus and instances
	// ****************************************************
	localparam int SC    = 50;
	localparam int LIMIT = 60000;

	logic             core_clk, rstn, da, follow, held;
	logic [15:0]      sp, fpos, pos, lg, pg, ti, td, band, qd, a1;
	logic [15:0]      out_a, out_b, rd;
	logic [1:0]       bst;
	logic [1:0][15:0] eng, amt, xamt;
	int               failures, tests_run, cycles;

	pvsb_servo #(.SAMPLE_CYCLES(SC)) u_dut (
		.core_clk(core_clk), .rstn(rstn), .set_point(sp),
		.valve_position(pos), .double_acting(da),
		.loop_gain_setting(lg), .plant_gain_estimate(pg),
		.integral_time(ti), .derivative_time(td),
		.derivative_term_gain(16'h0032), .integral_stop_band(band),
		.startup_output_level(16'h0fa0), .integral_hold_time(16'h0000),
		.quadratic_prop_divisor(qd), .kick_engage(eng),
		.kick_release({16'h0064, 16'h0064}), .kick_amount(amt),
		.vent_kick_engage_delta('0), .vent_kick_release_delta('0),
		.vent_kick_amount_delta(xamt), .pneumatic_output_a(out_a),
		.pneumatic_output_b(out_b), .drive_output_reading(rd),
		.boost_active(bst), .integral_held(held));

	pvsb_valve_model u_valve (.core_clk(core_clk), .rstn(rstn),
		.drive(out_a), .follow(follow), .forced_pos(fpos),
		.position(pos));

	// free-running clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			stop_test();
		end
	end

	// ****************************************************
	// tasks
	// ****************************************************
	task automatic run(input int n);
		repeat (n * SC) @(posedge core_clk);
		@(negedge core_clk);
	endtask
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic [15:0] s, input logic [15:0] p,
			input logic [15:0] a, input logic [15:0] b,
			input logic [15:0] r, input logic [1:0] k);
		sp = s;
		fpos = p;
		run(2);
		cmp16(out_a, a);
		cmp16(out_b, b);
		cmp16(rd, r);
		cmp2(bst, k);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		{rstn, da, follow, failures, tests_run, cycles} = '0;
		{sp, fpos} = {16'h1388, 16'h1388};
		{lg, pg, ti, td, band, qd} = {16'h04b0, 16'h0032, 64'h0};
		{eng, amt, xamt} = '0;
		repeat (5) @(negedge core_clk);
		cmp16(out_a, 16'h157c);
		repeat (5) @(negedge core_clk);
		rstn = 1'b1;
		@(negedge core_clk);
		cmp16(out_a, 16'h0fa0);
		go(16'h1388, 16'h0fa0, 16'h1090, 16'h0, 16'h1090, 2'b00);
		cmp2({1'b0, held}, 2'b01);
		go(16'h1388, 16'h1770, 16'h0eb0, 16'h0, 16'h0eb0, 2'b00);
		lg = 16'hffff;
		go(16'h1388, 16'h1324, 16'h10a4, 16'h0, 16'h10a4, 2'b00);
		{lg, pg} = {16'h04b0, 16'h0001};
		go(16'h1388, 16'h1324, 16'h1090, 16'h0, 16'h1090, 2'b00);
		{pg, qd} = {16'h0032, 16'h03e8};
		go(16'h1388, 16'h0fa0, 16'h1180, 16'h0, 16'h1180, 2'b00);
		go(16'h1388, 16'h07d0, 16'h1360, 16'h0, 16'h1360, 2'b00);
		{qd, lg} = {16'h0000, 16'h32c8};
		go(16'h1388, 16'h0000, 16'h2710, 16'h0, 16'h2710, 2'b00);
		go(16'h1388, 16'h2710, 16'h0000, 16'h0, 16'h0000, 2'b00);
		{lg, da} = {16'h04b0, 1'b1};
		go(16'h1388, 16'h0fa0, 16'h1090, 16'h1680, 16'h1090, 2'b00);
		{da, ti} = {1'b0, 16'h0014};
		run(10);
		cmp2({held, out_a > 16'h1090}, 2'b01);
		a1 = out_a;
		run(10);
		cmp2({1'b0, out_a > a1}, 2'b01);
		band = 16'h07d0;
		run(2);
		a1 = out_a;
		run(5);
		cmp16(out_a, a1);
		cmp2({1'b0, held}, 2'b01);
		{ti, band} = '0;
		go(16'h1388, 16'h0fa0, 16'h1090, 16'h0, 16'h1090, 2'b00);
		go(16'h1388, 16'h1388, 16'h0fa0, 16'h0, 16'h0fa0, 2'b00);
		eng = {16'h0122, 16'h00be};
		amt = {16'h03e8, 16'h0320};
		xamt = {16'hfe70, 16'h0000};
		run(2);
		go(16'h1450, 16'h1388, 16'h12f0, 16'h0, 16'h0fd0, 2'b01);
		go(16'h1450, 16'h1450, 16'h0fa0, 16'h0, 16'h0fa0, 2'b00);
		go(16'h1644, 16'h1450, 16'h1400, 16'h0, 16'h1018, 2'b10);
		go(16'h1644, 16'h1644, 16'h0fa0, 16'h0, 16'h0fa0, 2'b00);
		go(16'h1388, 16'h1644, 16'h0ef8, 16'h0, 16'h0ef8, 2'b00);
		go(16'h1388, 16'h1388, 16'h0fa0, 16'h0, 16'h0fa0, 2'b00);
		da = 1'b1;
		go(16'h1194, 16'h1388, 16'h0cd0, 16'h1a40, 16'h0f28, 2'b10);
		da = 1'b0;
		go(16'h1388, 16'h1388, 16'h1388, 16'h0, 16'h0fa0, 2'b10);
		td = 16'h00dc;
		run(300);
		fpos = 16'h13ec;
		run(2);
		cmp2({1'b0, out_a < 16'h0f88}, 2'b01);
		run(300);
		cmp2({1'b0, out_a > 16'h0f6e}, 2'b01);
		follow = 1'b1;
		run(20);
		cmp16(out_b, 16'h0000);
		stop_test();
	end
endmodule

`default_nettype wire
